/* File: rtl/mdm_phy_end.sv */
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// How it works
// [R1] both sample data line on clock rise
// [R2] works with clock stopped while idle
// [R3] strap address at reset, answer only it
// [R4] station sends one idle clock before each frame
// [R5] direct frames reach 32 16-bit registers
// [R6] frame starts with 01 from idle
// [R7] nobody drives first read turnaround bit
// [R8] read: drive zero, then 16 data bits
// [R9] write: station drives 10 and data
// [R10] release line unless driving read bits
// [R11] upper registers only reached indirectly
// [R12] indirect control 0x0d, address/data 0x0e
// [R13] control bits 4:0 select extended space
// [R14] four spaces: 11111, 00001, 00011, 00111
// [R15] station drops space nibble from address
// [R16] function 00 address, 01 plain data
// [R17] plain data writes hit same register
// [R18] station may skip resending stored address
// [R19] function 10 increments always, 11 writes
// [R20] plain data reads return selected register
// [R21] opcode, phy and register fields msb-first
// [R22] foreign frames ignored, line released
module mdm_phy_end import mdm_pkg::*; #(
	parameter int EXT_AW = MDM_EXT_AW
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [MDM_STRAP_W-1:0] phy_address_straps,
	output logic [MDM_STRAP_W-1:0] strap_addr,
	mdm_if.phy link
);
	typedef enum logic [2:0] {
		MDM_ST_IDLE = 3'h0,
		MDM_ST_START = 3'h1,
		MDM_ST_OP = 3'h3,
		MDM_ST_ADDR = 3'h2,
		MDM_ST_TA = 3'h6,
		MDM_ST_DATA = 3'h7
	} mdm_state_t;

	// ***********************************
	// synchronisers and edges
	// ***********************************
	logic [2:0] mdc_sync;
	logic [2:0] mdio_sync;
	logic mdc_lvl;
	logic mdio_lvl;
	logic cap_pend;
	always_ff @(posedge sys_clk) begin
		mdc_sync <= {mdc_sync[1:0], link.mdc};
		mdio_sync <= {mdio_sync[1:0], link.mdio};
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mdc_lvl <= 1'b0;
			mdio_lvl <= 1'b1;
		end else begin
			if (mdc_sync[1] == mdc_sync[2]) begin
				mdc_lvl <= mdc_sync[2];
			end
			if (mdio_sync[1] == mdio_sync[2]) begin
				mdio_lvl <= mdio_sync[2];
			end
		end
	end
	// [R2] edge driven only, no timeout
	wire mdc_rise = mdc_sync[1] & mdc_sync[2] & ~mdc_lvl;

	logic [MDM_STRAP_W-1:0] strap_sync [3];
	always_ff @(posedge sys_clk) begin
		strap_sync[0] <= phy_address_straps;
		strap_sync[1] <= strap_sync[0];
		strap_sync[2] <= strap_sync[1];
	end
	wire strap_agree = strap_sync[1] == strap_sync[2];
	// [R3] strap capture after reset release
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cap_pend <= 1'b1;
			strap_addr <= '0;
		end else if (cap_pend && strap_agree) begin
			cap_pend <= 1'b0;
			strap_addr <= strap_sync[2];
		end
	end

	// ***********************************
	// frame decoder
	// ***********************************
	mdm_state_t state, next_state;
	logic [MDM_CNT_W-1:0] cnt, next_cnt;
	logic [MDM_DATA_W-1:0] sr;
	logic [MDM_AD_W-1:0] reg_r;
	logic hit_wr;
	wire [MDM_DATA_W-1:0] shift_in = {sr[MDM_DATA_W-2:0], mdio_lvl};
	wire [MDM_OP_W-1:0] f_op = shift_in[MDM_ADDR_W+MDM_OP_W-1:MDM_ADDR_W];
	wire [MDM_AD_W-1:0] f_phy = shift_in[MDM_ADDR_W-1:MDM_AD_W];
	wire [MDM_AD_W-1:0] f_reg = shift_in[MDM_AD_W-1:0];
	// [R3] match strapped address
	wire addr_match = f_phy == {{(MDM_AD_W-MDM_STRAP_W){1'b0}}, strap_addr};
	wire addr_end = mdc_rise && state == MDM_ST_ADDR
		&& cnt == MDM_CNT_W'(MDM_ADDR_W - 1);
	wire data_end = mdc_rise && state == MDM_ST_DATA
		&& cnt == MDM_CNT_W'(MDM_DATA_W - 1);
	// [R22] foreign or bad opcode frames do nothing
	wire rd_go = addr_end && addr_match && f_op == MDM_OP_READ;
	wire wr_go = data_end && hit_wr;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		if (mdc_rise) begin
			next_cnt = cnt + 1'b1;
			unique case (state)
				MDM_ST_IDLE: begin
					// [R6] leaving idle on the first low bit
					if (!mdio_lvl) begin
						next_state = MDM_ST_START;
					end
				end
				MDM_ST_START: begin
					next_cnt = '0;
					next_state = mdio_lvl ? MDM_ST_OP : MDM_ST_IDLE;
				end
				MDM_ST_OP: begin
					if (cnt == MDM_CNT_W'(MDM_OP_W - 1)) begin
						next_cnt = '0;
						next_state = MDM_ST_ADDR;
					end
				end
				MDM_ST_ADDR: begin
					if (addr_end) begin
						next_cnt = '0;
						next_state = MDM_ST_TA;
					end
				end
				MDM_ST_TA: begin
					if (cnt == MDM_CNT_W'(MDM_TA_W - 1)) begin
						next_cnt = '0;
						next_state = MDM_ST_DATA;
					end
				end
				MDM_ST_DATA: begin
					if (data_end) begin
						next_state = MDM_ST_IDLE;
					end
				end
			endcase
		end
	end

	// [R1] shift on clock rise, [R21] msb first
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= MDM_ST_IDLE;
			cnt <= '0;
			sr <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			if (mdc_rise) begin
				sr <= shift_in;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_r <= '0;
			hit_wr <= 1'b0;
		end else if (addr_end) begin
			reg_r <= f_reg;
			hit_wr <= addr_match && f_op == MDM_OP_WRITE;
		end
	end

	// ***********************************
	// registers
	// ***********************************
	logic [MDM_DATA_W-1:0] ctrl;
	logic [MDM_DATA_W-1:0] ext_addr;
	logic [MDM_DATA_W-1:0] dir_mem [MDM_DIRECT_N];
	logic [MDM_DATA_W-1:0] ext_mem [4 << EXT_AW];
	wire [1:0] func = ctrl[MDM_FUNC_LSB+1:MDM_FUNC_LSB];
	// [R13] space select field
	wire [MDM_SEL_W-1:0] mmd_space_select = ctrl[MDM_SEL_W-1:0];
	// [R14] four extended spaces
	wire space_ok = mmd_space_select == MDM_SEL_VENDOR || mmd_space_select == MDM_SEL_STD1
		|| mmd_space_select == MDM_SEL_STD3 || mmd_space_select == MDM_SEL_STD7;
	wire [1:0] space_idx = mmd_space_select == MDM_SEL_STD1 ? 2'h1
		: mmd_space_select == MDM_SEL_STD3 ? 2'h2
		: mmd_space_select == MDM_SEL_STD7 ? 2'h3 : 2'h0;
	wire ext_hit = space_ok && ext_addr[MDM_DATA_W-1:EXT_AW] == '0;
	wire [EXT_AW+1:0] ext_idx = {space_idx, ext_addr[EXT_AW-1:0]};
	// [R16] function 00 means address access
	wire data_mode = func != MDM_FUNC_ADDR;
	// [R20] data mode reads selected register
	wire [MDM_DATA_W-1:0] ext_rd = ext_hit ? ext_mem[ext_idx] : '0;
	// [R11] [R12] indirect pair, rest direct
	wire [MDM_DATA_W-1:0] rd_mux = f_reg == MDM_REG_CTRL ? ctrl
		: f_reg == MDM_REG_ADDR ? (data_mode ? ext_rd : ext_addr) : dir_mem[f_reg];
	wire wr_ctrl = wr_go && reg_r == MDM_REG_CTRL;
	wire wr_addr = wr_go && reg_r == MDM_REG_ADDR;
	wire wr_dir = wr_go && !wr_ctrl && !wr_addr;
	// [R19] post-increment on reads only for 10
	wire inc_now = (wr_addr && (func == MDM_FUNC_INC_RW || func == MDM_FUNC_INC_WR))
		|| (rd_go && f_reg == MDM_REG_ADDR && func == MDM_FUNC_INC_RW);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl <= '0;
			ext_addr <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= shift_in & MDM_CTRL_MASK;
			end
			// [R16] load address in address mode
			if (wr_addr && !data_mode) begin
				ext_addr <= shift_in;
			end else if (inc_now) begin
				ext_addr <= ext_addr + 1'b1;
			end
		end
	end
	// [R17] data write goes to stored address
	always_ff @(posedge sys_clk) begin
		if (wr_addr && data_mode && ext_hit) begin
			ext_mem[ext_idx] <= shift_in;
		end
	end
	// [R5] direct register file
	for (genvar i = 0; i < MDM_DIRECT_N; i++) begin : g_dir
		always_ff @(posedge sys_clk) begin
			if (!nrst) begin
				dir_mem[i] <= '0;
			end else if (wr_dir && reg_r == MDM_AD_W'(i)) begin
				dir_mem[i] <= shift_in;
			end
		end
	end

	// ***********************************
	// read driver
	// ***********************************
	logic tx_arm;
	logic [MDM_DATA_W-1:0] tx_sr;
	logic [MDM_CNT_W-1:0] tx_left;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			tx_arm <= 1'b0;
			tx_sr <= '0;
			tx_left <= '0;
			link.phy_mdio_o <= 1'b1;
			link.phy_mdio_oe <= 1'b0;
		end else if (rd_go) begin
			// [R7] first turnaround bit left floating
			tx_arm <= 1'b1;
			tx_sr <= rd_mux;
		end else if (mdc_rise) begin
			if (tx_arm) begin
				// [R8] zero in second turnaround bit
				tx_arm <= 1'b0;
				tx_left <= MDM_TX_BITS;
				link.phy_mdio_o <= 1'b0;
				link.phy_mdio_oe <= 1'b1;
			end else if (tx_left != '0) begin
				// [R8] data bits msb first
				tx_left <= tx_left - 1'b1;
				tx_sr <= {tx_sr[MDM_DATA_W-2:0], 1'b0};
				link.phy_mdio_o <= tx_sr[MDM_DATA_W-1];
			end else begin
				// [R10] release after last data bit
				link.phy_mdio_o <= 1'b1;
				link.phy_mdio_oe <= 1'b0;
			end
		end
	end
endmodule

/* File: inc/mdm_pkg.sv */
package mdm_pkg;
	// ***********************************
	// frame layout
	// ***********************************
	localparam int MDM_OP_W = 2;
	localparam int MDM_AD_W = 5;
	localparam int MDM_ADDR_W = 2 * MDM_AD_W;
	localparam int MDM_TA_W = 2;
	localparam int MDM_DATA_W = 16;
	localparam int MDM_STRAP_W = 3;
	localparam int MDM_CNT_W = 5;
	localparam logic [1:0] MDM_OP_READ = 2'h2;
	localparam logic [1:0] MDM_OP_WRITE = 2'h1;
	localparam logic [1:0] MDM_START = 2'h1;
	localparam logic [1:0] MDM_TA_WRITE = 2'h2;
	// idle bit, start, op, phy, reg: last bit the station drives on a read
	localparam logic [5:0] MDM_BIT_HDR_LAST = 6'h0e;
	localparam logic [5:0] MDM_BIT_DATA_FIRST = 6'h11;
	localparam logic [5:0] MDM_BIT_LAST = 6'h20;
	localparam logic [4:0] MDM_TX_BITS = 5'h10;
	// ***********************************
	// register space
	// ***********************************
	localparam logic [4:0] MDM_REG_CTRL = 5'h0d;
	localparam logic [4:0] MDM_REG_ADDR = 5'h0e;
	localparam int MDM_DIRECT_N = 32;
	localparam int MDM_FUNC_LSB = 14;
	localparam int MDM_SEL_W = 5;
	localparam logic [15:0] MDM_CTRL_MASK = 16'hc01f;
	localparam logic [1:0] MDM_FUNC_ADDR = 2'h0;
	localparam logic [1:0] MDM_FUNC_DATA = 2'h1;
	localparam logic [1:0] MDM_FUNC_INC_RW = 2'h2;
	localparam logic [1:0] MDM_FUNC_INC_WR = 2'h3;
	localparam logic [4:0] MDM_SEL_VENDOR = 5'h1f;
	localparam logic [4:0] MDM_SEL_STD1 = 5'h01;
	localparam logic [4:0] MDM_SEL_STD3 = 5'h03;
	localparam logic [4:0] MDM_SEL_STD7 = 5'h07;
	localparam int MDM_EXT_AW = 6;
	// ***********************************
	// station registers and timing
	// ***********************************
	localparam int MDM_WB_AW = 4;
	localparam logic [3:0] MDM_WB_CMD = 4'h0;
	localparam logic [3:0] MDM_WB_WDATA = 4'h4;
	localparam logic [3:0] MDM_WB_RDATA = 4'h8;
	localparam logic [3:0] MDM_WB_STATUS = 4'hc;
	localparam int MDM_CMD_READ = 10;
	localparam int MDM_ST_BUSY = 0;
	localparam int MDM_ST_DONE = 1;
	localparam int MDM_SYS_PERIOD_NS = 8;
	localparam int MDM_MDC_HALF_NS = 64;
	localparam int MDM_MDC_HALF = MDM_MDC_HALF_NS / MDM_SYS_PERIOD_NS;
endpackage

/* File: inc/mdm_if.sv */
`timescale 1ns/1ps
interface mdm_if;
	logic mdc;
	logic sta_mdio_o;
	logic sta_mdio_oe;
	logic phy_mdio_o;
	logic phy_mdio_oe;
	logic mdio;
	// ***********************************
	// wire level, pull-up when released
	// ***********************************
	assign mdio = sta_mdio_oe ? sta_mdio_o : (phy_mdio_oe ? phy_mdio_o : 1'b1);
	modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
	modport phy (input mdc, output phy_mdio_o, output phy_mdio_oe, input mdio);
endinterface

/* File: rtl/mdm_station_end.sv */
`timescale 1ns/1ps
module mdm_station_end import mdm_pkg::*; #(
	parameter int MDC_HALF = MDM_MDC_HALF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [MDM_WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	mdm_if.station link
);
	// ***********************************
	// bus slave
	// ***********************************
	logic busy;
	logic done;
	logic cmd_read;
	logic [MDM_AD_W-1:0] cmd_phy;
	logic [MDM_AD_W-1:0] cmd_reg;
	logic [MDM_DATA_W-1:0] wdata;
	logic [MDM_DATA_W-1:0] rdata;
	logic finish;
	wire req = wb_cyc_i & wb_stb_i;
	wire wr_take = req & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire start = wr_take && wb_adr_i == MDM_WB_CMD && !busy;
	wire clr_done = wr_take && wb_adr_i == MDM_WB_STATUS && wb_dat_i[MDM_ST_DONE];
	wire [31:0] rd_mux = wb_adr_i == MDM_WB_CMD
		? {21'h0, cmd_read, cmd_phy, cmd_reg}
		: wb_adr_i == MDM_WB_WDATA ? {16'h0, wdata}
		: wb_adr_i == MDM_WB_RDATA ? {16'h0, rdata}
		: wb_adr_i == MDM_WB_STATUS ? {30'h0, done, busy} : 32'h0;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmd_read <= 1'b0;
			cmd_phy <= '0;
			cmd_reg <= '0;
			wdata <= '0;
			done <= 1'b0;
		end else begin
			if (start) begin
				{cmd_read, cmd_phy, cmd_reg} <= wb_dat_i[MDM_CMD_READ:0];
			end
			if (wr_take && wb_adr_i == MDM_WB_WDATA) begin
				wdata <= wb_dat_i[MDM_DATA_W-1:0];
			end
			// set wins over clear
			if (finish) begin
				done <= 1'b1;
			end else if (clr_done) begin
				done <= 1'b0;
			end
		end
	end

	// ***********************************
	// frame engine
	// ***********************************
	logic [2:0] mdio_sync;
	logic mdio_lvl;
	logic [7:0] div_cnt;
	logic [5:0] bit_idx;
	logic [31:0] tx_sr;
	wire tick = busy && div_cnt == 8'(MDC_HALF - 1);
	wire rise = tick && !link.mdc;
	wire fall = tick && link.mdc;
	assign finish = fall && bit_idx == MDM_BIT_LAST;
	always_ff @(posedge sys_clk) begin
		mdio_sync <= {mdio_sync[1:0], link.mdio};
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mdio_lvl <= 1'b1;
		end else if (mdio_sync[1] == mdio_sync[2]) begin
			mdio_lvl <= mdio_sync[2];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			busy <= 1'b0;
			div_cnt <= '0;
			bit_idx <= '0;
			tx_sr <= '0;
			rdata <= '0;
			link.mdc <= 1'b0;
			link.sta_mdio_o <= 1'b1;
			link.sta_mdio_oe <= 1'b0;
		end else if (start) begin
			// [R4] each frame opens with one idle clock
			busy <= 1'b1;
			div_cnt <= '0;
			bit_idx <= '0;
			// [R6] [R9] [R21] start, op, fields, turnaround
			tx_sr <= {MDM_START, wb_dat_i[MDM_CMD_READ] ? MDM_OP_READ : MDM_OP_WRITE,
				wb_dat_i[MDM_ADDR_W-1:0], MDM_TA_WRITE, wdata};
		end else if (busy) begin
			div_cnt <= tick ? '0 : div_cnt + 1'b1;
			if (tick) begin
				link.mdc <= ~link.mdc;
			end
			// [R1] sample read data on clock rise
			if (rise && cmd_read && bit_idx >= MDM_BIT_DATA_FIRST) begin
				rdata <= {rdata[MDM_DATA_W-2:0], mdio_lvl};
			end
			if (finish) begin
				busy <= 1'b0;
				link.sta_mdio_o <= 1'b1;
				link.sta_mdio_oe <= 1'b0;
			end else if (fall) begin
				bit_idx <= bit_idx + 1'b1;
				tx_sr <= {tx_sr[30:0], 1'b0};
				link.sta_mdio_o <= tx_sr[31];
				// [R7] release from first turnaround of a read
				link.sta_mdio_oe <= !cmd_read || bit_idx < MDM_BIT_HDR_LAST;
			end
		end
	end
endmodule

/* File: testbench/mdm_monitor.sv */
`timescale 1ns/1ps
module mdm_monitor import mdm_pkg::*; #(
	parameter int MDC_HALF = MDM_MDC_HALF
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic sta_mdio_o,
	input wire logic sta_mdio_oe,
	input wire logic phy_mdio_o,
	input wire logic phy_mdio_oe,
	input wire logic mdio
);
	localparam int SPAN_LO = 34 * MDC_HALF - 4;
	localparam int SPAN_HI = 34 * MDC_HALF + 4;
	logic [9:0] hi_cnt;
	logic [9:0] drv_cnt;
	wire [9:0] next_hi_cnt = mdc ? hi_cnt + 10'h001 : 10'h000;
	wire [9:0] next_drv_cnt = phy_mdio_oe ? drv_cnt + 10'h001 : 10'h000;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// ***********************************
	// run lengths
	// ***********************************
	always_ff @(posedge sys_clk) begin
		hi_cnt <= nrst ? next_hi_cnt : 10'h000;
		drv_cnt <= nrst ? next_drv_cnt : 10'h000;
	end
	// ***********************************
	// wire rules
	// ***********************************
	property p_no_contend;
		!(sta_mdio_oe && phy_mdio_oe);
	endproperty
	a_no_contend: assert property (p_no_contend)
		else $error("both ends drive the data line");
	property p_sta_edge;
		$changed({sta_mdio_o, sta_mdio_oe}) |-> !mdc;
	endproperty
	a_sta_edge: assert property (p_sta_edge)
		else $error("station changed data while clock high");
	property p_phy_edge;
		$changed({phy_mdio_o, phy_mdio_oe}) |-> mdc;
	endproperty
	a_phy_edge: assert property (p_phy_edge)
		else $error("device changed data while clock low");
	property p_phy_zero;
		$rose(phy_mdio_oe) |-> !phy_mdio_o && !sta_mdio_oe;
	endproperty
	a_phy_zero: assert property (p_phy_zero)
		else $error("device turnaround bit not zero");
	property p_start;
		$rose(sta_mdio_oe) |-> !sta_mdio_o [*8] ##[1:16] sta_mdio_o;
	endproperty
	a_start: assert property (p_start)
		else $error("frame start pattern wrong");
	property p_mdc_half;
		$fell(mdc) |-> hi_cnt == MDC_HALF;
	endproperty
	a_mdc_half: assert property (p_mdc_half)
		else $error("clock high phase wrong length");
	property p_phy_span;
		$fell(phy_mdio_oe) |-> drv_cnt >= SPAN_LO && drv_cnt <= SPAN_HI;
	endproperty
	a_phy_span: assert property (p_phy_span)
		else $error("device drive span wrong");
	property p_reset_quiet;
		$rose(nrst) |-> !mdc && !sta_mdio_oe && !phy_mdio_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("bus active out of reset");
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb import mdm_pkg::*;;
	logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, st;
	logic [2:0] phy_address_straps, strap_addr;
	logic [15:0] v;
	logic [4:0] sels [4] = '{MDM_SEL_VENDOR, MDM_SEL_STD1, MDM_SEL_STD3, MDM_SEL_STD7};
	int n_fail, total_checks;
	localparam logic [4:0] PHY = 5'h05;
	mdm_if link_if();
	mdm_station_end #(.MDC_HALF(MDM_MDC_HALF)) mdm_station_end_inst(.sys_clk(sys_clk),
		.nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .link(link_if));
	mdm_phy_end mdm_phy_end_inst(.sys_clk(sys_clk), .nrst(nrst),
		.phy_address_straps(phy_address_straps), .strap_addr(strap_addr), .link(link_if));
	mdm_monitor #(.MDC_HALF(MDM_MDC_HALF)) mdm_monitor_inst(.sys_clk(sys_clk), .nrst(nrst),
		.mdc(link_if.mdc), .sta_mdio_o(link_if.sta_mdio_o), .sta_mdio_oe(link_if.sta_mdio_oe),
		.phy_mdio_o(link_if.phy_mdio_o), .phy_mdio_oe(link_if.phy_mdio_oe), .mdio(link_if.mdio));
	// ***********************************
	// shared tasks
	// ***********************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] din);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= din;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		st = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic frame(input logic rd_op, input logic [4:0] phy, input logic [4:0] ra,
			input logic [15:0] wd);
		wb(1'b1, MDM_WB_WDATA, {16'h0000, wd});
		wb(1'b1, MDM_WB_CMD, {21'h000000, rd_op, phy, ra});
		do wb(1'b0, MDM_WB_STATUS, 32'h0); while (st[MDM_ST_BUSY] !== 1'b0);
		wb(1'b0, MDM_WB_RDATA, 32'h0);
		v = st[15:0];
	endtask
	task automatic pw(input logic [4:0] ra, input logic [15:0] wd);
		frame(1'b0, PHY, ra, wd);
	endtask
	task automatic pr(input logic [4:0] ra, input logic [15:0] exp);
		frame(1'b1, PHY, ra, 16'h0000);
		check({16'h0000, v}, {16'h0000, exp});
	endtask
	task automatic setad(input logic [4:0] sel, input logic [15:0] a, input logic [1:0] fn);
		pw(MDM_REG_CTRL, {MDM_FUNC_ADDR, 9'h000, sel});
		pw(MDM_REG_ADDR, a);
		pw(MDM_REG_CTRL, {fn, 9'h000, sel});
	endtask
	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_direct();
		check({29'h0, strap_addr}, 32'h5);
		pr(5'h05, 16'h0000);
		pw(5'h00, 16'ha5c3);
		pw(5'h1f, 16'h5a3c);
		pr(5'h00, 16'ha5c3);
		pr(5'h1f, 16'h5a3c);
		wb(1'b0, MDM_WB_STATUS, 32'h0);
		check(st, 32'h2);
		wb(1'b1, MDM_WB_STATUS, 32'h2);
		wb(1'b0, MDM_WB_STATUS, 32'h0);
		check(st, 32'h0);
	endtask
	task automatic t_foreign();
		frame(1'b0, 5'h15, 5'h00, 16'h1111);
		frame(1'b0, 5'h04, 5'h00, 16'h2222);
		pr(5'h00, 16'ha5c3);
		frame(1'b1, 5'h04, 5'h00, 16'h0000);
		check({16'h0, v}, 32'hffff);
	endtask
	task automatic t_spaces();
		for (int i = 0; i < 4; i++) begin
			setad(sels[i], 16'h003f, MDM_FUNC_DATA);
			pw(MDM_REG_ADDR, 16'h1000 + 16'(i));
		end
		for (int i = 0; i < 4; i++) begin
			setad(sels[i], 16'h003f, MDM_FUNC_DATA);
			pr(MDM_REG_ADDR, 16'h1000 + 16'(i));
		end
		pw(MDM_REG_ADDR, 16'h2222);
		pw(MDM_REG_ADDR, 16'h3333);
		pr(MDM_REG_ADDR, 16'h3333);
		setad(5'h02, 16'h0001, MDM_FUNC_DATA);
		pw(MDM_REG_ADDR, 16'h4444);
		pr(MDM_REG_ADDR, 16'h0000);
		pw(MDM_REG_CTRL, 16'h7fff);
		pr(MDM_REG_CTRL, 16'h401f);
	endtask
	task automatic t_incr();
		setad(MDM_SEL_VENDOR, 16'h0005, MDM_FUNC_INC_RW);
		pw(MDM_REG_ADDR, 16'h0c50);
		pw(MDM_REG_ADDR, 16'h0011);
		setad(MDM_SEL_VENDOR, 16'h0005, MDM_FUNC_INC_RW);
		pr(MDM_REG_ADDR, 16'h0c50);
		pr(MDM_REG_ADDR, 16'h0011);
		setad(MDM_SEL_VENDOR, 16'h0005, MDM_FUNC_INC_WR);
		pr(MDM_REG_ADDR, 16'h0c50);
		pr(MDM_REG_ADDR, 16'h0c50);
		pw(MDM_REG_ADDR, 16'h0777);
		pr(MDM_REG_ADDR, 16'h0011);
		pw(MDM_REG_CTRL, {MDM_FUNC_ADDR, 9'h000, MDM_SEL_VENDOR});
		pr(MDM_REG_ADDR, 16'h0006);
		pw(MDM_REG_CTRL, 16'h401f);
		pr(MDM_REG_ADDR, 16'h0011);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		nrst = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		phy_address_straps = 3'h5;
		n_fail = 0;
		total_checks = 0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_direct();
		t_foreign();
		t_spaces();
		t_incr();
		close_out();
	end
	initial begin
		#600000;
		n_fail++;
		close_out();
	end
endmodule
